/* verilog/dgp_unit.sv */
/*
 * Dedicated GPIO unit with two PWM channels behind a 16-bit register port.
 * Assumes the host port is on clk, one access per cycle, word indexed; pins
 * arrive asynchronously and are synchronised here.
 */
// Summary of operation
// - low-pin function bit 0 leaves pin to UART path, 1 gives it here
// - owned pin direction 0 is input, 1 output; reset is input
// - write-only set register: ones drive owned outputs high
// - write-only clear register: ones drive owned outputs low
// - every pin register is 16 bits, lower and upper half; function select has the lower half only
// - registers reset to zero
// - pwm high and low periods are 12 bits, upper bits read zero
// - falling-edge irq enable register for pins 31:16
// - state write drives owned outputs only; read returns live owned levels
// - owned input interrupts need mask and an edge enable
`timescale 1ns/1ps
`include "dgp_params.svh"

module dgp_unit
    import dgp_pkg::*;
#(
    parameter int PINS  = `DGP_PINS,
    parameter int PER_W = `DGP_PER_W
) (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    input  wire logic [`DGP_ADDR_W-1:0] reg_addr,
    input  wire logic [`DGP_REG_W-1:0]  reg_wdata,
    output logic      [`DGP_REG_W-1:0]  reg_rdata,
    input  wire logic [PINS-1:0]        pin_in,
    output logic      [PINS-1:0]        pin_out,
    output logic      [PINS-1:0]        pin_oe_n,
    input  wire logic [`DGP_HALF-1:0]   uart_out,
    input  wire logic [`DGP_HALF-1:0]   uart_oe_n,
    output logic                        edge_irq
);

    localparam int H = `DGP_HALF;

    logic [H-1:0]                       fsel_q, fsel_d;
    logic [PINS-1:0]                    dir_q, dir_d;
    logic [PINS-1:0]                    out_q, out_d;
    logic [PINS-1:0]                    mask_q, mask_d;
    logic [PINS-1:0]                    pos_q, pos_d;
    logic [PINS-1:0]                    neg_q, neg_d;
    logic [1:0][`DGP_CTL_W-1:0]         pctl_q, pctl_d;
    logic [1:0][PER_W-1:0]              phi_q, phi_d;
    logic [1:0][PER_W-1:0]              plo_q, plo_d;
    logic [`DGP_REG_W-1:0]              rdata_q, rdata_d;
    logic [PINS-1:0]                    meta_q, sync_q, prev_q;
    logic                               irq_q, irq_d;
    logic [PINS-1:0]                    pout_q, pout_d;
    logic [PINS-1:0]                    poe_n_q, poe_n_d;
    logic [PINS-1:0]                    owned, drive, pwm_sel, lvl, hits;
    logic [1:0]                         pwm_lvl;

    assign owned = {`DGP_HIGH_OWNED, fsel_q};
    assign drive = owned & dir_q;

    // ----------------------------------------
    // pwm channels
    // ----------------------------------------
    for (genvar c = 0; c < 2; c++) begin : g_pwm
        dgp_pwm #(.PER_W(PER_W)) u_pwm (
            .clk      (clk),
            .rst_n    (rst_n),
            .en       (pctl_q[c][`DGP_CTL_EN_BIT]),
            .high_cnt (phi_q[c]),
            .low_cnt  (plo_q[c]),
            .level    (pwm_lvl[c])
        );
    end

    // ----------------------------------------
    // pin synchroniser and edge detection
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= `DGP_RST_PINS;
            sync_q <= `DGP_RST_PINS;
            prev_q <= `DGP_RST_PINS;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // output pins never interrupt, whatever their mask
    assign hits = ((sync_q & ~prev_q & pos_q) | (~sync_q & prev_q & neg_q))
                  & mask_q & owned & ~dir_q;

    // ----------------------------------------
    // pin drive
    // ----------------------------------------
    // pwm wins over the latch on its pin; channel 1 wins a shared pin
    always_comb begin
        lvl     = out_q;
        pwm_sel = '0;
        for (int c = 0; c < 2; c++) begin
            if (pctl_q[c][`DGP_CTL_EN_BIT]) begin
                pwm_sel[pctl_q[c][`DGP_CTL_PIN_W-1:0]] = 1'b1;
                lvl[pctl_q[c][`DGP_CTL_PIN_W-1:0]]     = pwm_lvl[c];
            end
        end
        pwm_sel = pwm_sel & owned;
        pout_d  = lvl;
        poe_n_d = ~(drive | pwm_sel);
        pout_d[H-1:0]  = fsel_q & lvl[H-1:0] | ~fsel_q & uart_out;
        poe_n_d[H-1:0] = fsel_q & poe_n_d[H-1:0] | ~fsel_q & uart_oe_n;
        irq_d = |hits;
    end

    // ----------------------------------------
    // register writes and reads
    // ----------------------------------------
    always_comb begin
        fsel_d  = fsel_q;
        dir_d   = dir_q;
        out_d   = out_q;
        mask_d  = mask_q;
        pos_d   = pos_q;
        neg_d   = neg_q;
        pctl_d  = pctl_q;
        phi_d   = phi_q;
        plo_d   = plo_q;
        rdata_d = rdata_q;
        if (reg_wr) begin
            case (reg_addr)
                `DGP_OFF_FSEL:     fsel_d = reg_wdata;
                `DGP_OFF_DIR0:     dir_d[H-1:0] = reg_wdata;
                `DGP_OFF_DIR1:     dir_d[PINS-1:H] = reg_wdata;
                `DGP_OFF_SET0:     out_d[H-1:0] = out_q[H-1:0] | reg_wdata & drive[H-1:0];
                `DGP_OFF_SET1:     out_d[PINS-1:H] = out_q[PINS-1:H] | reg_wdata & drive[PINS-1:H];
                `DGP_OFF_CLR0:     out_d[H-1:0] = out_q[H-1:0] & ~(reg_wdata & drive[H-1:0]);
                `DGP_OFF_CLR1:     out_d[PINS-1:H] = out_q[PINS-1:H] & ~(reg_wdata & drive[PINS-1:H]);
                `DGP_OFF_STATE0:   out_d[H-1:0] = out_q[H-1:0] & ~drive[H-1:0]
                                                  | reg_wdata & drive[H-1:0];
                `DGP_OFF_STATE1:   out_d[PINS-1:H] = out_q[PINS-1:H] & ~drive[PINS-1:H]
                                                     | reg_wdata & drive[PINS-1:H];
                `DGP_OFF_MASK0:    mask_d[H-1:0] = reg_wdata;
                `DGP_OFF_MASK1:    mask_d[PINS-1:H] = reg_wdata;
                `DGP_OFF_POS0:     pos_d[H-1:0] = reg_wdata;
                `DGP_OFF_POS1:     pos_d[PINS-1:H] = reg_wdata;
                `DGP_OFF_NEG0:     neg_d[H-1:0] = reg_wdata;
                `DGP_OFF_NEG1:     neg_d[PINS-1:H] = reg_wdata;
                `DGP_OFF_PWM0_CTL: pctl_d[0] = reg_wdata[`DGP_CTL_W-1:0];
                `DGP_OFF_PWM1_CTL: pctl_d[1] = reg_wdata[`DGP_CTL_W-1:0];
                `DGP_OFF_PWM0_HI:  phi_d[0] = reg_wdata[PER_W-1:0];
                `DGP_OFF_PWM1_HI:  phi_d[1] = reg_wdata[PER_W-1:0];
                `DGP_OFF_PWM0_LO:  plo_d[0] = reg_wdata[PER_W-1:0];
                `DGP_OFF_PWM1_LO:  plo_d[1] = reg_wdata[PER_W-1:0];
                default: ;
            endcase
        end
        if (reg_rd) begin
            // set and clear are write only and read as zero, like any hole
            case (reg_addr)
                `DGP_OFF_FSEL:     rdata_d = fsel_q;
                `DGP_OFF_DIR0:     rdata_d = dir_q[H-1:0];
                `DGP_OFF_DIR1:     rdata_d = dir_q[PINS-1:H];
                `DGP_OFF_STATE0:   rdata_d = sync_q[H-1:0] & owned[H-1:0];
                `DGP_OFF_STATE1:   rdata_d = sync_q[PINS-1:H] & owned[PINS-1:H];
                `DGP_OFF_MASK0:    rdata_d = mask_q[H-1:0];
                `DGP_OFF_MASK1:    rdata_d = mask_q[PINS-1:H];
                `DGP_OFF_POS0:     rdata_d = pos_q[H-1:0];
                `DGP_OFF_POS1:     rdata_d = pos_q[PINS-1:H];
                `DGP_OFF_NEG0:     rdata_d = neg_q[H-1:0];
                `DGP_OFF_NEG1:     rdata_d = neg_q[PINS-1:H];
                `DGP_OFF_PWM0_CTL: rdata_d = `DGP_REG_W'(pctl_q[0]);
                `DGP_OFF_PWM1_CTL: rdata_d = `DGP_REG_W'(pctl_q[1]);
                `DGP_OFF_PWM0_HI:  rdata_d = `DGP_REG_W'(phi_q[0]);
                `DGP_OFF_PWM1_HI:  rdata_d = `DGP_REG_W'(phi_q[1]);
                `DGP_OFF_PWM0_LO:  rdata_d = `DGP_REG_W'(plo_q[0]);
                `DGP_OFF_PWM1_LO:  rdata_d = `DGP_REG_W'(plo_q[1]);
                default:           rdata_d = `DGP_RST_REG;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fsel_q  <= `DGP_RST_REG;
            dir_q   <= `DGP_RST_PINS;
            out_q   <= `DGP_RST_PINS;
            mask_q  <= `DGP_RST_PINS;
            pos_q   <= `DGP_RST_PINS;
            neg_q   <= `DGP_RST_PINS;
            pctl_q  <= {2{`DGP_RST_CTL}};
            phi_q   <= {2{`DGP_RST_PER}};
            plo_q   <= {2{`DGP_RST_PER}};
            rdata_q <= `DGP_RST_REG;
            irq_q   <= 1'b0;
            pout_q  <= `DGP_RST_PINS;
            poe_n_q <= ~`DGP_RST_PINS;
        end else begin
            fsel_q  <= fsel_d;
            dir_q   <= dir_d;
            out_q   <= out_d;
            mask_q  <= mask_d;
            pos_q   <= pos_d;
            neg_q   <= neg_d;
            pctl_q  <= pctl_d;
            phi_q   <= phi_d;
            plo_q   <= plo_d;
            rdata_q <= rdata_d;
            irq_q   <= irq_d;
            pout_q  <= pout_d;
            poe_n_q <= poe_n_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign pin_out   = pout_q;
    assign pin_oe_n  = poe_n_q;
    assign edge_irq  = irq_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_wr(logic [`DGP_ADDR_W-1:0] a);
        reg_wr && reg_addr == a;
    endsequence

    uart_route_a: assert property (!fsel_q[0] |=> pin_out[0] == $past(uart_out[0]))
        else $error("unowned pin not on uart path");
    dir_input_a: assert property (owned[1] && !dir_q[1] && !pwm_sel[1] |=> pin_oe_n[1])
        else $error("owned input pin is driven");
    set_drive_a: assert property (s_wr(`DGP_OFF_SET0) && reg_wdata[2] && drive[2]
        |=> out_q[2] && !pwm_sel[2] |=> pin_out[2])
        else $error("set did not drive pin high");
    clear_drive_a: assert property (s_wr(`DGP_OFF_CLR0) && reg_wdata[3] && drive[3]
        |=> !out_q[3])
        else $error("clear did not drive pin low");
    width_read_a: assert property (reg_rd && reg_addr == `DGP_OFF_PWM1_CTL
        |=> reg_rdata[`DGP_REG_W-1:`DGP_CTL_W] == '0)
        else $error("control register upper bits not zero");
    reset_zero_a: assert property (@(posedge clk) disable iff (1'b0) !rst_n
        |=> dir_q == '0 && fsel_q == '0 && out_q == '0 && !edge_irq)
        else $error("register not zero after reset");
    pwm_field_a: assert property (s_wr(`DGP_OFF_PWM0_CTL)
        |=> pctl_q[0] == $past(reg_wdata[`DGP_CTL_W-1:0]))
        else $error("pwm control field not stored");
    period_read_a: assert property (reg_rd && reg_addr == `DGP_OFF_PWM0_HI
        |=> reg_rdata == `DGP_REG_W'($past(phi_q[0])))
        else $error("period readback wrong");
    neg_irq_a: assert property (neg_q[16] && mask_q[16] && owned[16] && !dir_q[16]
        && prev_q[16] && !sync_q[16] |=> edge_irq)
        else $error("falling edge on high pin lost");
    state_ignore_a: assert property (s_wr(`DGP_OFF_STATE0) && !drive[4]
        |=> $stable(out_q[4]))
        else $error("state write changed a non-output pin");
    irq_gate_a: assert property (edge_irq |-> $past(|(mask_q & owned & ~dir_q)))
        else $error("interrupt without an enabled input");
    set_ignore_a: assert property (s_wr(`DGP_OFF_SET1) && !drive[20]
        |=> $stable(out_q[20]))
        else $error("set changed a pin it does not drive");

endmodule : dgp_unit

/* verilog/dgp_params.svh */
/*
 * Register indices, field positions, reset values and widths of the dedicated
 * GPIO/PWM unit. Assumes the host register port carries a word index, not bytes.
 */
`ifndef DGP_PARAMS_SVH
`define DGP_PARAMS_SVH

// ----------------------------------------
// register indices
// ----------------------------------------
`define DGP_ADDR_W       10
`define DGP_OFF_FSEL     10'h3c0
`define DGP_OFF_DIR0     10'h3c1
`define DGP_OFF_SET0     10'h3c2
`define DGP_OFF_CLR0     10'h3c3
`define DGP_OFF_STATE0   10'h3c4
`define DGP_OFF_MASK0    10'h3c9
`define DGP_OFF_POS0     10'h3ca
`define DGP_OFF_NEG0     10'h3cb
`define DGP_OFF_DIR1     10'h3cd
`define DGP_OFF_SET1     10'h3ce
`define DGP_OFF_CLR1     10'h3cf
`define DGP_OFF_STATE1   10'h3d0
`define DGP_OFF_MASK1    10'h3d5
`define DGP_OFF_POS1     10'h3d6
`define DGP_OFF_NEG1     10'h3d7
`define DGP_OFF_PWM0_CTL 10'h3d8
`define DGP_OFF_PWM0_HI  10'h3d9
`define DGP_OFF_PWM0_LO  10'h3da
`define DGP_OFF_PWM1_CTL 10'h3db
`define DGP_OFF_PWM1_HI  10'h3dc
`define DGP_OFF_PWM1_LO  10'h3dd

// ----------------------------------------
// widths, fields and reset values
// ----------------------------------------
`define DGP_REG_W        16
`define DGP_PINS         32
`define DGP_HALF         16
`define DGP_CTL_W        9
`define DGP_PER_W        12
`define DGP_CTL_EN_BIT   5
`define DGP_CTL_PIN_LSB  0
`define DGP_CTL_PIN_W    5
`define DGP_RST_REG      16'h0000
`define DGP_RST_PINS     32'h0000_0000
`define DGP_RST_CTL      9'h000
`define DGP_RST_PER      12'h000
`define DGP_HIGH_OWNED   16'hffff

`endif

/* verilog/dgp_pkg.sv */
/*
 * Types shared by the dedicated GPIO/PWM unit and its PWM channel.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package dgp_pkg;

    // ----------------------------------------
    // pwm channel phases
    // ----------------------------------------
    typedef enum logic [1:0] {
        DGP_PWM_IDLE,
        DGP_PWM_HIGH,
        DGP_PWM_LOW
    } dgp_pwm_state_t;

endpackage : dgp_pkg

/* verilog/dgp_pwm.sv */
/*
 * One PWM channel: high for the high count, low for the low count, repeating.
 * Assumes counts are stable software values on the same clock.
 */
`timescale 1ns/1ps
`include "dgp_params.svh"

module dgp_pwm
    import dgp_pkg::*;
#(
    parameter int PER_W = `DGP_PER_W
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             en,
    input  wire logic [PER_W-1:0] high_cnt,
    input  wire logic [PER_W-1:0] low_cnt,
    output logic                  level
);

    dgp_pwm_state_t   state_q, state_d;
    logic [PER_W-1:0] cnt_q, cnt_d;
    logic             level_q, level_d;

    // ----------------------------------------
    // phase sequencing
    // ----------------------------------------
    // a phase lasts max(count,1) cycles; a zero count cannot stall the wave
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q + PER_W'(1);
        level_d = 1'b0;
        unique case (state_q)
            DGP_PWM_IDLE: begin
                cnt_d = '0;
                if (en) begin
                    state_d = DGP_PWM_HIGH;
                    level_d = 1'b1;
                end
            end
            DGP_PWM_HIGH: begin
                level_d = 1'b1;
                if (cnt_q + PER_W'(1) >= high_cnt) begin
                    state_d = DGP_PWM_LOW;
                    cnt_d   = '0;
                    level_d = 1'b0;
                end
            end
            DGP_PWM_LOW: begin
                if (cnt_q + PER_W'(1) >= low_cnt) begin
                    state_d = DGP_PWM_HIGH;
                    cnt_d   = '0;
                    level_d = 1'b1;
                end
            end
        endcase
        if (!en) begin
            state_d = DGP_PWM_IDLE;
            cnt_d   = '0;
            level_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= DGP_PWM_IDLE;
            cnt_q   <= '0;
            level_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            level_q <= level_d;
        end
    end

    assign level = level_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_high_end;
        en && state_q == DGP_PWM_HIGH && cnt_q + PER_W'(1) >= high_cnt;
    endsequence

    sequence s_low_end;
        en && state_q == DGP_PWM_LOW && cnt_q + PER_W'(1) >= low_cnt;
    endsequence

    pwm_fall_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_high_end |=> !level_q)
        else $error("pwm did not drop after high phase");

    pwm_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_low_end |=> level_q && state_q == DGP_PWM_HIGH)
        else $error("pwm did not rise after low phase");

    pwm_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        !en |=> !level_q && state_q == DGP_PWM_IDLE)
        else $error("disabled pwm still active");

endmodule : dgp_pwm

/* tb/dgp_pin_model.sv */
/*
 * Load model for the 32 pins of the dedicated GPIO/PWM unit.
 * Assumes the bench supplies each peripheral's drive and its enable.
 */
`timescale 1ns/1ps

module dgp_pin_model (
    input  wire logic [31:0] pin_out,
    input  wire logic [31:0] pin_oe_n,
    input  wire logic [31:0] ext_val,
    input  wire logic [31:0] ext_en,
    output logic      [31:0] pin_in
);
    // ----------------------------------------
    // wire level per pin
    // ----------------------------------------
    // a line that nobody drives floats up through its pull-up
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            if (!pin_oe_n[i] && ext_en[i] && pin_out[i] !== ext_val[i])
                pin_in[i] = 1'bx;
            else if (!pin_oe_n[i])
                pin_in[i] = pin_out[i];
            else if (ext_en[i])
                pin_in[i] = ext_val[i];
            else
                pin_in[i] = 1'b1;
        end
    end
endmodule : dgp_pin_model

/* tb/dedicated_gpio_pwm_block_tb_top.sv */
/*
 * Bench for dgp_unit: register table loop, then pin, interrupt and pwm cases.
 * Assumes dgp_params.svh on the include path and dgp_pin_model as pin load.
 */
`timescale 1ns/1ps
`include "dgp_params.svh"

module dedicated_gpio_pwm_block_tb_top
    import dgp_pkg::*;
;
    typedef struct {
        logic [`DGP_ADDR_W-1:0] addr;
        logic [`DGP_REG_W-1:0]  wdata;
        logic [`DGP_REG_W-1:0]  rexp;
    } dgp_row_t;

    logic                   clk             = 1'b0;
    logic                   rst_n           = 1'b0;
    logic                   reg_wr          = 1'b0;
    logic                   reg_rd          = 1'b0;
    logic [`DGP_ADDR_W-1:0] reg_addr        = 10'h000;
    logic [`DGP_REG_W-1:0]  reg_wdata       = 16'h0000;
    logic [`DGP_REG_W-1:0]  reg_rdata;
    logic [31:0]            pin_in;
    logic [31:0]            pin_out;
    logic [31:0]            pin_oe_n;
    logic [15:0]            uart_out        = 16'h0000;
    logic [15:0]            uart_oe_n       = 16'hffff;
    logic                   edge_irq;
    logic [31:0]            ext_val         = 32'h1234_0000;
    logic [31:0]            ext_en          = 32'hffff_0000;
    int                     error_cnt       = 0;
    int                     samples_checked = 0;
    int                     irq_cnt         = 0;
    int                     c0;

    dgp_row_t rows [12] = '{
        '{`DGP_OFF_FSEL, 16'hffff, 16'hffff},
        '{`DGP_OFF_DIR0, 16'h00ff, 16'h00ff},
        '{`DGP_OFF_SET0, 16'hffff, 16'h0000},
        '{`DGP_OFF_CLR0, 16'hffff, 16'h0000},
        '{`DGP_OFF_NEG1, 16'h8001, 16'h8001},
        '{`DGP_OFF_PWM0_CTL, 16'hffff, 16'h01ff},
        '{`DGP_OFF_PWM0_HI, 16'hffff, 16'h0fff},
        '{`DGP_OFF_PWM0_LO, 16'h1234, 16'h0234},
        '{`DGP_OFF_PWM1_CTL, 16'hfe5f, 16'h005f},
        '{`DGP_OFF_PWM1_LO, 16'hf001, 16'h0001},
        '{`DGP_OFF_MASK1, 16'h5a5a, 16'h5a5a},
        '{10'h3c5, 16'hffff, 16'h0000}
    };

    dgp_unit dut_u (
        .clk       (clk),
        .rst_n     (rst_n),
        .reg_wr    (reg_wr),
        .reg_rd    (reg_rd),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_rdata (reg_rdata),
        .pin_in    (pin_in),
        .pin_out   (pin_out),
        .pin_oe_n  (pin_oe_n),
        .uart_out  (uart_out),
        .uart_oe_n (uart_oe_n),
        .edge_irq  (edge_irq)
    );

    dgp_pin_model load_u (
        .pin_out  (pin_out),
        .pin_oe_n (pin_oe_n),
        .ext_val  (ext_val),
        .ext_en   (ext_en),
        .pin_in   (pin_in)
    );

    always #4 clk = ~clk;

    always @(posedge clk) begin
        if (edge_irq === 1'b1)
            irq_cnt <= irq_cnt + 1;
    end

    // ----------------------------------------
    // bus, compare and closing tasks
    // ----------------------------------------
    task automatic reg_write(input logic [9:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr    = 1'b0;
    endtask : reg_write

    task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check_val

    task automatic check_cnt(input string what, input int exp, input int got);
        samples_checked++;
        if (got != exp) begin
            error_cnt++;
            $display("Error %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check_cnt

    task automatic rd_check(input logic [9:0] a, input logic [15:0] exp, input string what);
        @(negedge clk);
        reg_rd   = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd   = 1'b0;
        check_val(what, {16'h0000, exp}, {16'h0000, reg_rdata});
    endtask : rd_check

    task automatic wait_cycles(input int n);
        repeat (n) @(negedge clk);
    endtask : wait_cycles

    task automatic dgp_reset;
        rst_n = 1'b0;
        wait_cycles(3);
        rst_n = 1'b1;
    endtask : dgp_reset

    // pin change must give exactly the expected number of pulses
    task automatic irq_try(input int pin, input logic lvl, input int exp);
        int c;
        @(negedge clk);
        ext_val[pin] = lvl;
        c = irq_cnt;
        wait_cycles(8);
        check_cnt("edge_irq_pulses", exp, irq_cnt - c);
    endtask : irq_try

    task automatic pwm_measure(input int pin, input int hi, input int lo);
        int n;
        int h;
        int l;
        n = 0;
        h = 0;
        l = 0;
        while (pin_out[pin] !== 1'b0 && n < 60) begin
            @(negedge clk);
            n++;
        end
        while (pin_out[pin] !== 1'b1 && n < 60) begin
            @(negedge clk);
            n++;
        end
        if (n >= 60) begin
            check_cnt("pwm_start_wait", 0, n);
            complete_run();
        end
        while (pin_out[pin] === 1'b1 && h < 60) begin
            @(negedge clk);
            h++;
        end
        while (pin_out[pin] === 1'b0 && l < 60) begin
            @(negedge clk);
            l++;
        end
        check_cnt("pwm_high_cycles", hi, h);
        check_cnt("pwm_low_cycles", lo, l);
    endtask : pwm_measure

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        dgp_reset();
        for (int a = 'h3c0; a <= 'h3dd; a++)
            // upper pins are always owned, so their state shows the live peripheral levels
            rd_check(a[9:0], (a == `DGP_OFF_STATE1) ? ext_val[31:16] : 16'h0000, "reset_value");
        check_val("oe_n_after_reset", 32'hffff_ffff, pin_oe_n);
        foreach (rows[i]) begin
            reg_write(rows[i].addr, rows[i].wdata);
            rd_check(rows[i].addr, rows[i].rexp, "table_readback");
        end
        // second reset also has to stop pwm channel 0, left running on pin 31 by the table
        dgp_reset();
        wait_cycles(1);
        check_val("oe_n_after_rerun", 32'hffff_ffff, pin_oe_n);
        uart_out  = 16'h3c3c;
        uart_oe_n = 16'h00ff;
        wait_cycles(2);
        check_val("uart_out_path", 32'h3c3c, {16'h0000, pin_out[15:0]});
        check_val("uart_oe_path", 32'h00ff, {16'h0000, pin_oe_n[15:0]});
        reg_write(`DGP_OFF_FSEL, 16'h00ff);
        reg_write(`DGP_OFF_DIR0, 16'hf0f0);
        reg_write(`DGP_OFF_SET0, 16'hffff);
        wait_cycles(1);
        check_val("oe_n_mixed", 32'h000f, {16'h0000, pin_oe_n[15:0]});
        check_val("driven_set", 32'h3cf0, {16'h0000, pin_out[15:0] & ~pin_oe_n[15:0]});
        reg_write(`DGP_OFF_CLR0, 16'h0030);
        wait_cycles(1);
        check_val("driven_clear", 32'h3cc0, {16'h0000, pin_out[15:0] & ~pin_oe_n[15:0]});
        reg_write(`DGP_OFF_FSEL, 16'hffff);
        reg_write(`DGP_OFF_DIR0, 16'hffff);
        wait_cycles(1);
        check_val("latch_kept", 32'h00c0, {16'h0000, pin_out[15:0]});
        wait_cycles(3);
        rd_check(`DGP_OFF_STATE0, 16'h00c0, "state_of_outputs");
        reg_write(`DGP_OFF_STATE0, 16'h0f0f);
        wait_cycles(4);
        rd_check(`DGP_OFF_STATE0, 16'h0f0f, "state_written");
        reg_write(`DGP_OFF_DIR0, 16'h0000);
        reg_write(`DGP_OFF_STATE0, 16'hffff);
        wait_cycles(4);
        rd_check(`DGP_OFF_STATE0, 16'hffff, "state_pulled_up");
        rd_check(`DGP_OFF_STATE1, 16'h1234, "state_of_inputs");
        reg_write(`DGP_OFF_DIR0, 16'h00ff);
        wait_cycles(1);
        check_val("state_write_ignored", 32'h000f, {24'h000000, pin_out[7:0]});

        // ----------------------------------------
        // interrupts on the upper pins
        // ----------------------------------------
        reg_write(`DGP_OFF_MASK1, 16'h0005);
        reg_write(`DGP_OFF_NEG1, 16'h0003);
        reg_write(`DGP_OFF_POS1, 16'h0004);
        wait_cycles(4);
        irq_try(16, 1'b1, 0);
        irq_try(16, 1'b0, 1);
        irq_try(17, 1'b1, 0);
        irq_try(17, 1'b0, 0);
        irq_try(18, 1'b0, 0);
        irq_try(18, 1'b1, 1);
        ext_en[31:16] = 16'h0000;
        wait_cycles(8);
        c0 = irq_cnt;
        reg_write(`DGP_OFF_DIR1, 16'h0001);
        reg_write(`DGP_OFF_SET1, 16'h0001);
        wait_cycles(2);
        check_val("upper_output_set", 32'h1, {31'h0, pin_out[16]});
        reg_write(`DGP_OFF_CLR1, 16'h0001);
        wait_cycles(8);
        check_cnt("output_pin_irq", 0, irq_cnt - c0);

        // ----------------------------------------
        // pwm channels
        // ----------------------------------------
        reg_write(`DGP_OFF_PWM0_HI, 16'h0002);
        reg_write(`DGP_OFF_PWM0_LO, 16'h0003);
        reg_write(`DGP_OFF_PWM0_CTL, 16'h0034);
        pwm_measure(20, 2, 3);
        check_val("pwm_pin_driven", 32'h0, {31'h0, pin_oe_n[20]});
        reg_write(`DGP_OFF_PWM1_HI, 16'h0001);
        reg_write(`DGP_OFF_PWM1_LO, 16'h0004);
        reg_write(`DGP_OFF_PWM1_CTL, 16'h01f5);
        rd_check(`DGP_OFF_PWM1_CTL, 16'h01f5, "pwm1_control");
        pwm_measure(21, 1, 4);
        reg_write(`DGP_OFF_PWM0_CTL, 16'h0000);
        wait_cycles(2);
        check_val("pwm_released", 32'h1, {31'h0, pin_oe_n[20]});
        complete_run();
    end
endmodule : dedicated_gpio_pwm_block_tb_top
